// >>> design/gst_timer.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module gst_timer
	import gst_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic extCountPin,
	input wire logic gatePin,
	input wire logic comparatorOutput,
	input wire logic lpOscClk,
	input wire logic sleepMode,
	output logic interruptReq,
	output logic wakeReq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Pin synchronisers: 0 count pin, 1 gate pin, 2 comparator, 3 osc
	logic [3:0] syncA, syncB, syncPrev;
	logic [3:0] next_syncA, next_syncB, next_syncPrev;

	always_comb begin
		next_syncA = {lpOscClk, comparatorOutput, gatePin, extCountPin};
		next_syncB = syncA;
		next_syncPrev = syncB;
	end

	// Bus state
	logic awHeld, wHeld, wLane, bValid, rValid, awReady, wReady, arReady;
	logic [AXI_ADDR_W-1:0] awAddr;
	logic [7:0] wByte;
	logic [1:0] bResp, rResp;
	logic [31:0] rData;
	logic next_awHeld, next_wHeld, next_wLane, next_bValid, next_rValid;
	logic next_awReady, next_wReady, next_arReady;
	logic [AXI_ADDR_W-1:0] next_awAddr;
	logic [7:0] next_wByte;
	logic [1:0] next_bResp, next_rResp;
	logic [31:0] next_rData;
	logic doWrite, wrLo, wrHi, wrIrq, wrCtrl, wrCfg, cntWrite;

	// Block state
	gst_ctrl_s ctrl, next_ctrl;
	gst_irq_s irqReg, next_irqReg;
	gst_cfg_s cfg, next_cfg;
	gst_arm_e armState, next_armState;
	logic [15:0] count, next_count;
	logic [1:0] divCnt, next_divCnt;
	logic next_interruptReq, next_wakeReq;

	logic useLp, extLevel, extPrev, extRise, extFall;
	logic instrTick, srcTick, gateLevel, gateOk, asyncMode, runOk;
	logic qualTick, countPulse, wrapNow;

	always_comb begin
		next_awHeld = awHeld;
		next_awAddr = awAddr;
		next_wHeld = wHeld;
		next_wByte = wByte;
		next_wLane = wLane;
		next_bValid = bValid;
		next_bResp = bResp;
		if (s_axi_awvalid && awReady) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && wReady) begin
			next_wHeld = 1'b1;
			next_wByte = s_axi_wdata[7:0];
			next_wLane = s_axi_wstrb[0];
		end
		if (bValid && s_axi_bready) begin
			next_bValid = 1'b0;
		end
		doWrite = awHeld && wHeld && !bValid;
		wrLo = 1'b0;
		wrHi = 1'b0;
		wrIrq = 1'b0;
		wrCtrl = 1'b0;
		wrCfg = 1'b0;
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bValid = 1'b1;
			next_bResp = RESP_OKAY;
			// Only lane 0 carries data; other lanes are accepted and dropped
			if (awAddr == CNT_LO_OFFSET) begin
				wrLo = wLane;
			end else if (awAddr == CNT_HI_OFFSET) begin
				wrHi = wLane;
			end else if (awAddr == IRQ_OFFSET) begin
				wrIrq = wLane;
			end else if (awAddr == CTRL_OFFSET) begin
				wrCtrl = wLane;
			end else if (awAddr == CFG_OFFSET) begin
				wrCfg = wLane;
			end else begin
				next_bResp = RESP_SLVERR;
			end
		end
		cntWrite = wrLo || wrHi;
		next_awReady = !next_awHeld && !next_bValid;
		next_wReady = !next_wHeld && !next_bValid;
	end

	always_comb begin
		next_rValid = rValid;
		next_rData = rData;
		next_rResp = rResp;
		if (rValid && s_axi_rready) begin
			next_rValid = 1'b0;
		end
		if (s_axi_arvalid && arReady) begin
			next_rValid = 1'b1;
			next_rResp = RESP_OKAY;
			next_rData = 32'h0000_0000;
			// Count lives in this clock domain, so a read is always settled
			if (s_axi_araddr == CNT_LO_OFFSET) begin
				next_rData[7:0] = count[7:0];
			end else if (s_axi_araddr == CNT_HI_OFFSET) begin
				next_rData[7:0] = count[15:8];
			end else if (s_axi_araddr == IRQ_OFFSET) begin
				next_rData[IRQ_FLAG_BIT] = irqReg.overflowFlag;
				next_rData[IRQ_IE_BIT] = irqReg.overflowIntEnable;
				next_rData[IRQ_PERIPHERAL_INT_ENABLE_BIT] = irqReg.peripheralIntEnable;
				next_rData[IRQ_GIE_BIT] = irqReg.globalIntEnable;
			end else if (s_axi_araddr == CTRL_OFFSET) begin
				next_rData[7:0] = ctrl;
			end else if (s_axi_araddr == CFG_OFFSET) begin
				next_rData[CFG_GATE_SRC_BIT] = cfg.gateSourceSelect;
				next_rData[CFG_INTERNAL_OSCILLATOR_BIT] = cfg.intoscNoClkout;
			end else begin
				next_rResp = RESP_SLVERR;
			end
		end
		// Derived from the answer, so it also rises on the first edge after reset
		next_arReady = !next_rValid;
	end

	// Count source, gate and edge arming
	always_comb begin
		next_divCnt = 2'(divCnt + 2'h1);
		instrTick = divCnt == INSTR_LAST;
		useLp = ctrl.lpOscEnable && cfg.intoscNoClkout;
		extLevel = useLp ? syncB[3] : syncB[0];
		extPrev = useLp ? syncPrev[3] : syncPrev[0];
		extRise = extLevel && !extPrev;
		extFall = !extLevel && extPrev;
		next_armState = armState;
		if (!ctrl.timerOn || !ctrl.clockSourceSelect) begin
			next_armState = ARM_WAIT_FALL;
		end else begin
			case (armState)
				ARM_WAIT_FALL: if (extFall) begin
					next_armState = ARM_READY;
				end
				default: next_armState = ARM_READY;
			endcase
		end
		if (ctrl.clockSourceSelect) begin
			srcTick = extRise && armState == ARM_READY;
		end else begin
			srcTick = instrTick;
		end
		gateLevel = (cfg.gateSourceSelect ? syncB[2] : syncB[1])
			^ ctrl.gateInvert;
		gateOk = !ctrl.gateEnable || gateLevel;
		asyncMode = ctrl.clockSourceSelect && ctrl.extSyncDisable;
		runOk = ctrl.timerOn && gateOk && (!sleepMode || asyncMode);
		qualTick = srcTick && runOk;
	end

	gst_prescaler u_prescaler (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tickIn(qualTick),
		.clear(cntWrite),
		.select(ctrl.prescaleSelect),
		.tickOut(countPulse)
	);

	always_comb begin
		next_count = count;
		next_ctrl = ctrl;
		next_cfg = cfg;
		next_irqReg = irqReg;
		wrapNow = countPulse && !cntWrite && count == COUNT_MAX;
		if (countPulse && !cntWrite) begin
			next_count = 16'(count + COUNT_STEP);
		end
		if (wrLo) begin
			next_count[7:0] = wByte;
		end
		if (wrHi) begin
			next_count[15:8] = wByte;
		end
		if (wrCtrl) begin
			next_ctrl = gst_ctrl_s'(wByte);
		end
		if (wrCfg) begin
			next_cfg.gateSourceSelect = wByte[CFG_GATE_SRC_BIT];
			next_cfg.intoscNoClkout = wByte[CFG_INTERNAL_OSCILLATOR_BIT];
		end
		if (wrIrq) begin
			next_irqReg.overflowFlag = wByte[IRQ_FLAG_BIT];
			next_irqReg.overflowIntEnable = wByte[IRQ_IE_BIT];
			next_irqReg.peripheralIntEnable = wByte[IRQ_PERIPHERAL_INT_ENABLE_BIT];
			next_irqReg.globalIntEnable = wByte[IRQ_GIE_BIT];
		end
		// A wrap in the clearing cycle still lands
		if (wrapNow) begin
			next_irqReg.overflowFlag = 1'b1;
		end
		next_wakeReq = irqReg.overflowFlag && irqReg.overflowIntEnable
			&& irqReg.peripheralIntEnable;
		next_interruptReq = next_wakeReq && irqReg.globalIntEnable;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA <= 4'h0;
			syncB <= 4'h0;
			syncPrev <= 4'h0;
			awHeld <= 1'b0;
			awAddr <= 8'h00;
			wHeld <= 1'b0;
			wByte <= 8'h00;
			wLane <= 1'b0;
			bValid <= 1'b0;
			bResp <= RESP_OKAY;
			awReady <= 1'b0;
			wReady <= 1'b0;
			arReady <= 1'b0;
			rValid <= 1'b0;
			rData <= 32'h0000_0000;
			rResp <= RESP_OKAY;
			ctrl <= CTRL_RESET;
			cfg <= CFG_RESET;
			irqReg <= IRQ_RESET;
			armState <= ARM_WAIT_FALL;
			count <= COUNT_WRAP;
			divCnt <= 2'h0;
			interruptReq <= 1'b0;
			wakeReq <= 1'b0;
		end else begin
			syncA <= next_syncA;
			syncB <= next_syncB;
			syncPrev <= next_syncPrev;
			awHeld <= next_awHeld;
			awAddr <= next_awAddr;
			wHeld <= next_wHeld;
			wByte <= next_wByte;
			wLane <= next_wLane;
			bValid <= next_bValid;
			bResp <= next_bResp;
			awReady <= next_awReady;
			wReady <= next_wReady;
			arReady <= next_arReady;
			rValid <= next_rValid;
			rData <= next_rData;
			rResp <= next_rResp;
			ctrl <= next_ctrl;
			cfg <= next_cfg;
			irqReg <= next_irqReg;
			armState <= next_armState;
			count <= next_count;
			divCnt <= next_divCnt;
			interruptReq <= next_interruptReq;
			wakeReq <= next_wakeReq;
		end
	end

	always_comb begin
		s_axi_awready = awReady;
		s_axi_wready = wReady;
		s_axi_bvalid = bValid;
		s_axi_bresp = bResp;
		s_axi_arready = arReady;
		s_axi_rvalid = rValid;
		s_axi_rdata = rData;
		s_axi_rresp = rResp;
	end

	AST_WRAP_SETS_FLAG: assert property (
		(countPulse && !cntWrite && count == COUNT_MAX)
		|=> (count == COUNT_WRAP && irqReg.overflowFlag))
		else $error("wrap did not clear count and set flag");
	AST_STEP_ONE: assert property (
		(countPulse && !cntWrite) |=> count == $past(count) + COUNT_STEP)
		else $error("count did not advance by one");
	AST_FLAG_STICKY: assert property (
		(irqReg.overflowFlag && !wrIrq) |=> irqReg.overflowFlag)
		else $error("overflow flag dropped without software write");
	AST_IRQ_GATING: assert property (
		interruptReq == $past(irqReg.overflowFlag
			&& irqReg.overflowIntEnable && irqReg.peripheralIntEnable
			&& irqReg.globalIntEnable))
		else $error("interrupt request does not follow enables");
	AST_INSTR_RATE: assert property (
		instrTick |=> !instrTick [*3] ##1 instrTick)
		else $error("instruction tick not every fourth cycle");
	AST_ARM_FALL: assert property (
		(ctrl.clockSourceSelect && armState == ARM_WAIT_FALL) |-> !qualTick)
		else $error("rising edge counted before falling edge");
	AST_OFF_HOLDS: assert property (
		(!ctrl.timerOn && !cntWrite) |=> count == $past(count))
		else $error("count moved while timer off");
	AST_GATE_BLOCKS: assert property (
		(ctrl.gateEnable && !gateLevel) |-> !qualTick)
		else $error("count tick passed a closed gate");
	AST_SLEEP_SYNC: assert property (
		(sleepMode && !asyncMode) |-> !qualTick)
		else $error("synchronous source counted in sleep");
	AST_CLEAN_READ: assert property (
		(s_axi_arvalid && arReady && s_axi_araddr == CNT_LO_OFFSET)
		|=> rData[7:0] == $past(count[7:0]))
		else $error("low count byte read mismatch");
endmodule // gst_timer

// >>> design/gst_pkg.sv
// Contract
// - Count wraps FFFFh to 0000h, sets flag
// - Interrupt needs enable, peripheral and global bits
// - Timer mode counts core clock divided four
// - Counter mode counts external rising edges
// - Rising edge counts only after falling edge
// - Prescale field divides by 1, 2, 4, 8
// - Prescaler hidden; count byte write clears it
// - Gate from pin or comparator output
// - Gate enable needed for any gate effect
// - Gated timer runs only while gate inactive; code runs it only while gate level after invert is high
// - Gate invert bit flips either gate source
// - Oscillator enable acts only without clock out
// - Sync bit matters only for external clock
// - Clock source bit picks external or internal
// - Asynchronous counter keeps counting during sleep
// - Count byte reads always return settled value
package gst_pkg;
	localparam int AXI_ADDR_W = 8;
	localparam logic [7:0] CNT_LO_OFFSET = 8'h00;
	localparam logic [7:0] CNT_HI_OFFSET = 8'h04;
	localparam logic [7:0] IRQ_OFFSET = 8'h08;
	localparam logic [7:0] CTRL_OFFSET = 8'h10;
	localparam logic [7:0] CFG_OFFSET = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int IRQ_FLAG_BIT = 0;
	localparam int IRQ_IE_BIT = 1;
	localparam int IRQ_PERIPHERAL_INT_ENABLE_BIT = 6;
	localparam int IRQ_GIE_BIT = 7;
	localparam int CFG_GATE_SRC_BIT = 0;
	localparam int CFG_INTERNAL_OSCILLATOR_BIT = 1;

	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_WRAP = 16'h0000;
	localparam logic [15:0] COUNT_STEP = 16'h0001;

	localparam int CORE_CLK_PERIOD_NS = 5;
	localparam int INSTR_DIV = 4;
	localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

	localparam logic [1:0] PRESC_DIV1 = 2'h0;
	localparam logic [1:0] PRESC_DIV2 = 2'h1;
	localparam logic [1:0] PRESC_DIV4 = 2'h2;
	localparam logic [2:0] PRESC_MASK1 = 3'h0;
	localparam logic [2:0] PRESC_MASK2 = 3'h1;
	localparam logic [2:0] PRESC_MASK4 = 3'h3;
	localparam logic [2:0] PRESC_MASK8 = 3'h7;

	typedef struct packed {
		logic gateInvert;
		logic gateEnable;
		logic [1:0] prescaleSelect;
		logic lpOscEnable;
		logic extSyncDisable;
		logic clockSourceSelect;
		logic timerOn;
	} gst_ctrl_s;

	typedef struct packed {
		logic globalIntEnable;
		logic peripheralIntEnable;
		logic overflowIntEnable;
		logic overflowFlag;
	} gst_irq_s;

	typedef struct packed {
		logic intoscNoClkout;
		logic gateSourceSelect;
	} gst_cfg_s;

	localparam gst_ctrl_s CTRL_RESET = 8'h00;
	localparam gst_irq_s IRQ_RESET = 4'h0;
	localparam gst_cfg_s CFG_RESET = 2'h0;

	typedef enum logic {ARM_WAIT_FALL, ARM_READY} gst_arm_e;
endpackage

// >>> design/gst_prescaler.sv
`timescale 1ns/1ps
module gst_prescaler
	import gst_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic tickIn,
	input wire logic clear,
	input wire logic [1:0] select,
	output logic tickOut
);
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic [2:0] mask;

	always_comb begin
		case (select)
			PRESC_DIV1: mask = PRESC_MASK1;
			PRESC_DIV2: mask = PRESC_MASK2;
			PRESC_DIV4: mask = PRESC_MASK4;
			default: mask = PRESC_MASK8;
		endcase
		// Free-running count: low bits all ones marks every 2^n-th tick
		tickOut = tickIn && !clear && ((cnt & mask) == mask);
		next_cnt = cnt;
		if (clear) begin
			next_cnt = 3'h0;
		end else if (tickIn) begin
			next_cnt = 3'(cnt + 3'h1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 3'h0;
		end else begin
			cnt <= next_cnt;
		end
	end

	AST_PRESC_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
		clear |=> cnt == 3'h0)
		else $error("prescaler not cleared by count write");
	AST_PRESC_DIV8: assert property (@(posedge core_clk) disable iff (!rst_n)
		(tickOut && select == 2'h3) |-> cnt == 3'h7)
		else $error("divide by eight pulse off phase");
endmodule // gst_prescaler

// >>> verification/gst_pin_model.sv
`timescale 1ns/1ps
module gst_pin_model (
	output logic extCountPin,
	output logic lpOscClk,
	output logic gatePin,
	output logic comparatorOutput
);
	localparam int HALF_NS = 80;

	initial begin
		extCountPin = 1'h0;
		lpOscClk = 1'h0;
		gatePin = 1'h0;
		comparatorOutput = 1'h0;
	end

	// Unused source gets the opposite level, so a wrong select shows up
	task automatic set_gate(input logic level, input logic useComp);
		#1;
		gatePin = useComp ? ~level : level;
		comparatorOutput = useComp ? level : ~level;
	endtask

	// Clocks stand low between frames; odd offset keeps edges off core_clk
	task automatic pulses(input int n, input logic onLp);
		#1.3;
		repeat (n) begin
			{lpOscClk, extCountPin} = onLp ? 2'h2 : 2'h1;
			#HALF_NS;
			{lpOscClk, extCountPin} = 2'h0;
			#HALF_NS;
		end
	endtask
endmodule // gst_pin_model

// >>> verification/tb_gated_sixteen_bit_timer.sv
`timescale 1ns/1ps
module tb_gated_sixteen_bit_timer;
	import gst_pkg::*;

	// Control, config, gate level, sleep, pulse frame, frame on lp clock
	typedef struct packed {
		logic [7:0] ctrl;
		logic [1:0] cfg;
		logic level;
		logic sleep;
		logic pulse;
		logic onLp;
		logic [1:0] spare;
	} gst_case_s;

	localparam int WAIT_CYC = 200;
	localparam int PULSES = 9;
	localparam gst_case_s CASES [25] = '{
		16'h0100, 16'h1100, 16'h2100, 16'h3100, 16'h0500,
		16'h0000, 16'h4000, 16'h4100, 16'h4120, 16'h4160,
		16'h4140, 16'hC100, 16'hC160, 16'h8100, 16'h0308,
		16'h0708, 16'h1308, 16'h3308, 16'h0718, 16'h0318,
		16'h0110, 16'h0B8C, 16'h0B88, 16'h0B08, 16'h4308
	};
	localparam int EN_BITS [3] = '{IRQ_IE_BIT, IRQ_PERIPHERAL_INT_ENABLE_BIT, IRQ_GIE_BIT};

	logic core_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0;
	logic [AXI_ADDR_W-1:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, sleepMode = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, interruptReq, wakeReq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic extCountPin, gatePin, comparatorOutput, lpOscClk;
	logic [15:0] rnd = 16'h001F;
	int error_cnt = 0;
	int num_checks = 0;

	always #2.5 core_clk = ~core_clk;

	gst_timer uut (
		.core_clk(core_clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .extCountPin(extCountPin),
		.gatePin(gatePin), .comparatorOutput(comparatorOutput),
		.lpOscClk(lpOscClk), .sleepMode(sleepMode),
		.interruptReq(interruptReq), .wakeReq(wakeReq)
	);

	gst_pin_model pins (
		.extCountPin(extCountPin), .lpOscClk(lpOscClk),
		.gatePin(gatePin), .comparatorOutput(comparatorOutput)
	);

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Expected count change; timer mode allows for divider phase and the
	// few cycles the stopping write takes
	function automatic int expect_cnt(input gst_case_s c, input int upper);
		gst_ctrl_s t;
		int d;
		int span;
		logic run;
		t = c.ctrl;
		d = 1 << t.prescaleSelect;
		run = t.timerOn && (!t.gateEnable || (c.level ^ t.gateInvert));
		if (c.sleep && !(t.clockSourceSelect && t.extSyncDisable)) run = 0;
		if (!run) return 0;
		span = WAIT_CYC + 4 * upper;
		if (!t.clockSourceSelect) return span / (4 * d) + upper;
		if ((t.lpOscEnable && c.cfg[CFG_INTERNAL_OSCILLATOR_BIT]) != c.onLp) return 0;
		return (PULSES - 1) / d;
	endfunction

	task automatic check(input logic [31:0] got, input int lo, input int hi);
		num_checks++;
		if ((got >= lo && got <= hi) !== 1'h1) begin
			error_cnt++;
			$display("[FAIL] %0t got %0h want %0d..%0d", $time, got, lo, hi);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
		output logic [1:0] resp);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] resp);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	// Random preload through the count bytes also clears the prescaler
	task automatic measure(input gst_case_s c, output logic [15:0] delta);
		logic [31:0] lo;
		logic [31:0] hi;
		logic [1:0] r;
		rnd = lfsr_next(rnd);
		pins.set_gate(c.level, c.cfg[CFG_GATE_SRC_BIT]);
		axi_wr(CFG_OFFSET, {6'h00, c.cfg}, r);
		axi_wr(CNT_LO_OFFSET, rnd[7:0], r);
		axi_wr(CNT_HI_OFFSET, rnd[15:8], r);
		sleepMode <= c.sleep;
		axi_wr(CTRL_OFFSET, c.ctrl, r);
		if (c.pulse) pins.pulses(PULSES, c.onLp);
		else repeat (WAIT_CYC) @(posedge core_clk);
		axi_wr(CTRL_OFFSET, 8'h00, r);
		sleepMode <= 1'h0;
		axi_rd(CNT_LO_OFFSET, lo, r);
		axi_rd(CNT_HI_OFFSET, hi, r);
		delta = {hi[7:0], lo[7:0]} - rnd;
	endtask

	task automatic complete_run;
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// About seven thousand cycles of work; over four times that is a hang
	initial begin
		#150_000;
		error_cnt++;
		complete_run;
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [15:0] delta;
		int lo;
		int hi;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge core_clk);
		axi_rd(CTRL_OFFSET, d, r);
		check(d, 0, 0);
		axi_wr(CTRL_OFFSET, 8'hF6, r);
		s_axi_wstrb <= 4'h0;
		axi_wr(CTRL_OFFSET, 8'h00, r);
		s_axi_wstrb <= 4'h1;
		axi_rd(CTRL_OFFSET, d, r);
		check(d, 8'hF6, 8'hF6);
		axi_rd(8'h0C, d, r);
		check(d, 0, 0);
		check(r, RESP_SLVERR, RESP_SLVERR);
		axi_wr(8'h18, 8'h55, r);
		check(r, RESP_SLVERR, RESP_SLVERR);
		foreach (CASES[i]) begin
			measure(CASES[i], delta);
			lo = expect_cnt(CASES[i], 0);
			hi = expect_cnt(CASES[i], 1);
			if (CASES[i].pulse) check(delta, lo, hi);
			else check(delta, lo, hi);
		end
		axi_wr(IRQ_OFFSET, 8'h00, r);
		axi_wr(CNT_LO_OFFSET, 8'hFF, r);
		axi_wr(CNT_HI_OFFSET, 8'hFF, r);
		axi_wr(IRQ_OFFSET, 8'hC2, r);
		axi_wr(CTRL_OFFSET, 8'h01, r);
		repeat (20) @(posedge core_clk);
		axi_wr(CTRL_OFFSET, 8'h00, r);
		check(interruptReq, 1, 1);
		axi_rd(IRQ_OFFSET, d, r);
		check(d, 8'hC3, 8'hC3);
		axi_rd(CNT_LO_OFFSET, d, r);
		check(d, 4, 6);
		foreach (EN_BITS[i]) begin
			axi_wr(IRQ_OFFSET, 8'hC3 & ~(8'h01 << EN_BITS[i]), r);
			repeat (4) @(posedge core_clk);
			lo = (EN_BITS[i] == IRQ_GIE_BIT);
			check({interruptReq, wakeReq}, lo, lo);
		end
		axi_wr(IRQ_OFFSET, 8'hC2, r);
		repeat (4) @(posedge core_clk);
		check(interruptReq, 0, 0);
		axi_rd(IRQ_OFFSET, d, r);
		check(d, 8'hC2, 8'hC2);
		complete_run;
	end
endmodule // tb_gated_sixteen_bit_timer
